// ==== hdl/prs_page_select.sv ====
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module prs_page_select #(
  parameter int BASE_W = 16
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Register port
  input  wire logic [prs_pkg::RA_W-1:0]   i_addr,
  input  wire logic [prs_pkg::WORD_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [prs_pkg::WORD_W-1:0]      o_rdata,
  // Core references
  input  wire prs_pkg::prs_req_t      i_req,
  output prs_pkg::prs_rsp_t           o_rsp,
  // Status word and privilege
  input  wire logic                   i_vec_load,
  input  wire logic                   i_psw_wr,
  input  wire logic [prs_pkg::WORD_W-1:0] i_new_psw,
  input  wire logic                   i_exec_priv,
  output logic                        o_priv_fault,
  output logic [prs_pkg::MODE_W-1:0]      o_stack_bank,
  output logic [prs_pkg::MODE_W-1:0]      o_cur_mode
);
  import prs_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [IDX_W-1:0] set_idx(
    input logic [MODE_W-1:0] m,
    input logic              d,
    input logic [PAGE_W-1:0] p
  );
    return {m, d, p};
  endfunction : set_idx

  function automatic logic dsp_for(
    input logic [CTL3_W-1:0] c,
    input logic [MODE_W-1:0] m
  );
    logic r;
    r = 1'b0;
    if (m == MODE_KERNEL) begin
      r = c[CTL3_KERNEL];
    end else if (m == MODE_SUPER) begin
      r = c[CTL3_SUPER];
    end else if (m == MODE_USER) begin
      r = c[CTL3_USER];
    end
    return r;
  endfunction : dsp_for

  // ****************************************
  // State
  // ****************************************
  logic [WORD_W-1:0] base_mem [NUM_SETS];
  logic [WORD_W-1:0] desc_mem [NUM_SETS];
  logic [CTL3_W-1:0] ctl3;
  logic              map_en;
  logic [MODE_W-1:0] cur_mode;
  logic [BASE_W-1:0] last_blk;

  // ****************************************
  // Register decode
  // ****************************************
  wire               reg_area = ~i_addr[REG_AREA_BIT];
  wire               reg_kind = i_addr[REG_KIND_BIT];
  wire [IDX_W-1:0]   reg_idx  = set_idx(
    i_addr[REG_MODE_HI:REG_MODE_LO], i_addr[REG_SPC_BIT],
    i_addr[PAGE_W-1:0]);
  wire               wr_base  = i_wr & reg_area & ~reg_kind;
  wire               wr_desc  = i_wr & reg_area & reg_kind;
  wire               wr_ctl3  = i_wr & (i_addr == ADDR_CTL3);
  wire               wr_map   = i_wr & (i_addr == ADDR_MAPCTL);
  wire [WORD_W-1:0]  rd_pair  = reg_kind ? desc_mem[reg_idx]
                                         : base_mem[reg_idx];
  logic [WORD_W-1:0] next_rdata;

  always_comb begin
    if (!i_rd) begin
      next_rdata = RST_WORD;
    end else if (reg_area) begin
      next_rdata = rd_pair;
    end else if (i_addr == ADDR_CTL3) begin
      next_rdata = {{(WORD_W-CTL3_W){1'b0}}, ctl3};
    end else if (i_addr == ADDR_MAPCTL) begin
      next_rdata = {{(WORD_W-1){1'b0}}, map_en};
    end else if (i_addr == ADDR_STATUS) begin
      next_rdata = {cur_mode, {(WORD_W-MODE_W){1'b0}}};
    end else if (i_addr == ADDR_LASTBLK) begin
      next_rdata = WORD_W'(last_blk);
    end else begin
      next_rdata = RST_WORD;
    end
  end

  // ****************************************
  // Translation
  // ****************************************
  // Vector words live in kernel space whatever mode runs
  wire               is_vec   = i_req.cls == CLS_VECTOR;
  wire [MODE_W-1:0]  eff_mode = is_vec ? MODE_KERNEL
                                       : cur_mode;
  wire               d_class  = (i_req.cls == CLS_DATA)
                              | (i_req.cls == CLS_INDIRECT)
                              | is_vec;
  wire               use_d    = d_class
                              & dsp_for(ctl3, eff_mode);
  wire [PAGE_W-1:0]  page_sel = i_req.vaddr[PAGE_HI:PAGE_LO];
  wire [IDX_W-1:0]   lk_idx   = set_idx(eff_mode, use_d,
                                        page_sel);
  wire [WORD_W-1:0]  base_reg = base_mem[lk_idx];
  wire [BASE_W-1:0]  base_fld = base_reg[BASE_W-1:0];
  wire [BLK_W-1:0]   blk_idx  = i_req.vaddr[BLK_HI:BLK_LO];
  wire [BASE_W-1:0]  phys_blk = base_fld
                              + BASE_W'(blk_idx);
  wire [PA_W-1:0]    map_pa   = PA_W'({phys_blk,
                                i_req.vaddr[DISP_W-1:0]});
  wire [PA_W-1:0]    raw_pa   = PA_W'(i_req.vaddr);
  // Register operands never touch memory
  wire               mem_ref  = i_req.valid
                              & (i_req.cls != CLS_REGISTER);
  prs_rsp_t          next_rsp;

  always_comb begin
    next_rsp.valid  = mem_ref;
    next_rsp.paddr  = map_en ? map_pa : raw_pa;
    next_rsp.dspace = map_en & use_d;
    next_rsp.mode   = eff_mode;
  end

  // ****************************************
  // Mode and privilege
  // ****************************************
  // Vector load and plain status write both take the mode from i_new_psw
  wire               mode_ld   = i_vec_load | i_psw_wr;
  wire [MODE_W-1:0]  next_mode = mode_ld
    ? i_new_psw[PSW_MODE_HI:PSW_MODE_LO] : cur_mode;
  wire               next_flt  = i_exec_priv
                               & (cur_mode != MODE_KERNEL);

  assign o_stack_bank = cur_mode;
  assign o_cur_mode   = cur_mode;

  // ****************************************
  // Flops
  // ****************************************
  // Page pairs are two separate 16-bit words, one in base_mem and one in desc_mem
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NUM_SETS; k++) begin
        base_mem[k] <= RST_WORD;
        desc_mem[k] <= RST_WORD;
      end
    end else begin
      if (wr_base) begin
        base_mem[reg_idx] <= i_wdata;
      end
      if (wr_desc) begin
        desc_mem[reg_idx] <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl3 <= RST_CTL3;
      map_en <= 1'b0;
      cur_mode <= MODE_KERNEL;
      o_priv_fault <= 1'b0;
      o_rdata <= RST_WORD;
    end else begin
      if (wr_ctl3) begin
        ctl3 <= i_wdata[CTL3_W-1:0];
      end
      if (wr_map) begin
        map_en <= i_wdata[MAPEN_BIT];
      end
      cur_mode <= next_mode;
      o_priv_fault <= next_flt;
      o_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp <= '0;
      last_blk <= '0;
    end else begin
      o_rsp <= next_rsp;
      if (mem_ref && map_en) begin
        last_blk <= phys_blk;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_vector_kernel: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && is_vec) |=> (o_rsp.mode == MODE_KERNEL))
    else $error("vector not mapped through kernel set");

  chk_stack_bank: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_vec_load |=> (o_stack_bank ==
      $past(i_new_psw[PSW_MODE_HI:PSW_MODE_LO])))
    else $error("stack bank not from new status");

  chk_mode_follow: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_vec_load ##1 (i_req.valid && !is_vec))
      |=> (o_rsp.mode == $past(i_new_psw[PSW_MODE_HI:PSW_MODE_LO], 2)))
    else $error("page set does not follow new mode");

  chk_priv_refuse: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_exec_priv && cur_mode != MODE_KERNEL) |=> o_priv_fault)
    else $error("privileged op not refused");

  chk_kernel_priv: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (cur_mode == MODE_KERNEL) |=> !o_priv_fault)
    else $error("kernel op refused");

  chk_ispace_fetch: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && !d_class) |=> !o_rsp.dspace)
    else $error("stream fetch went to data space");

  chk_dspace_off: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && !dsp_for(ctl3, eff_mode)) |=> !o_rsp.dspace)
    else $error("data space used while disabled");

  chk_reg_nomap: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.cls == CLS_REGISTER) |=> !o_rsp.valid)
    else $error("register operand made a reference");

  chk_block_sum: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (mem_ref && map_en) |=>
      (o_rsp.paddr[DISP_W-1:0] == $past(i_req.vaddr[DISP_W-1:0]))
      && (o_rsp.paddr[BASE_W+DISP_W-1:DISP_W] == $past(phys_blk)))
    else $error("physical block or displacement wrong");

  chk_data_dspace: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (mem_ref && map_en && i_req.cls == CLS_DATA
      && dsp_for(ctl3, cur_mode)) |=> o_rsp.dspace)
    else $error("operand not in data space");

  chk_rsp_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_req.valid |=> !o_rsp.valid)
    else $error("response without a request");

  chk_ref_answer: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && i_req.cls != CLS_REGISTER) |=> o_rsp.valid)
    else $error("memory reference not answered");

  chk_map_off: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (mem_ref && !map_en) |=> (o_rsp.paddr == PA_W'($past(i_req.vaddr))))
    else $error("unmapped address was relocated");

  chk_dspace_map: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !map_en |=> !o_rsp.dspace)
    else $error("data space flagged with mapping off");

  chk_vector_dspace: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && is_vec && map_en && ctl3[CTL3_KERNEL]) |=> o_rsp.dspace)
    else $error("vector missed kernel data set");

  chk_vector_ispace: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_req.valid && is_vec && !ctl3[CTL3_KERNEL]) |=> !o_rsp.dspace)
    else $error("vector used disabled kernel data set");

  chk_fault_pulse: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_exec_priv |=> !o_priv_fault)
    else $error("fault without a privileged attempt");

  chk_psw_load: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_psw_wr |=> (o_cur_mode == $past(i_new_psw[PSW_MODE_HI:PSW_MODE_LO])))
    else $error("status write did not load mode");

  chk_mode_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !(i_vec_load || i_psw_wr) |=> $stable(o_cur_mode))
    else $error("mode changed without a load");

  chk_ctl3_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_ctl3 |=> (ctl3 == $past(i_wdata[CTL3_W-1:0])))
    else $error("space enables not written");

  chk_ctl3_hold: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !wr_ctl3 |=> $stable(ctl3))
    else $error("space enables changed unasked");

  chk_map_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_map |=> (map_en == $past(i_wdata[MAPEN_BIT])))
    else $error("mapping enable not written");

  chk_base_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_base |=> (base_mem[$past(reg_idx)] == $past(i_wdata)))
    else $error("base register not written");

  chk_desc_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_desc |=> (desc_mem[$past(reg_idx)] == $past(i_wdata)))
    else $error("descriptor register not written");

  chk_pair_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && reg_area) |=> (o_rdata == $past(rd_pair)))
    else $error("page register read wrong");

  chk_status_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == ADDR_STATUS)
      |=> (o_rdata[PSW_MODE_HI:PSW_MODE_LO] == $past(cur_mode)))
    else $error("status read lost the mode");

  chk_rdata_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_rd |=> (o_rdata == RST_WORD))
    else $error("read data outside its cycle");

  chk_last_block: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (mem_ref && map_en)
      |=> (last_blk == o_rsp.paddr[BASE_W+DISP_W-1:DISP_W]))
    else $error("last block not captured");

endmodule : prs_page_select

// ==== hdl/prs_pkg.sv ====
package prs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int VA_W      = 16;
  localparam int WORD_W    = 16;
  localparam int PA_W      = 22;
  localparam int RA_W      = 8;
  localparam int BLK_W     = 7;
  localparam int DISP_W    = 6;
  localparam int PAGE_W    = 3;
  localparam int MODE_W    = 2;
  localparam int IDX_W     = 6;
  localparam int NUM_SETS  = 64;
  localparam int CTL3_W    = 3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PSW_MODE_HI  = 15;
  localparam int PSW_MODE_LO  = 14;
  localparam int PAGE_HI      = 15;
  localparam int PAGE_LO      = 13;
  localparam int BLK_HI       = 12;
  localparam int BLK_LO       = 6;
  localparam int REG_AREA_BIT = 7;
  localparam int REG_KIND_BIT = 6;
  localparam int REG_MODE_HI  = 5;
  localparam int REG_MODE_LO  = 4;
  localparam int REG_SPC_BIT  = 3;
  localparam int MAPEN_BIT    = 0;
  localparam int CTL3_KERNEL  = 2;
  localparam int CTL3_SUPER   = 1;
  localparam int CTL3_USER    = 0;

  // ****************************************
  // Modes, offsets, reset values
  // ****************************************
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER  = 2'h1;
  localparam logic [1:0] MODE_USER   = 2'h3;

  localparam logic [7:0] ADDR_CTL3    = 8'h80;
  localparam logic [7:0] ADDR_MAPCTL  = 8'h81;
  localparam logic [7:0] ADDR_STATUS  = 8'h82;
  localparam logic [7:0] ADDR_LASTBLK = 8'h83;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  RST_CTL3 = 3'h0;

  typedef enum logic [2:0] {
    CLS_INSTR    = 3'b000,
    CLS_IMM      = 3'b001,
    CLS_ABS      = 3'b010,
    CLS_INDEX    = 3'b011,
    CLS_DATA     = 3'b100,
    CLS_INDIRECT = 3'b101,
    CLS_VECTOR   = 3'b110,
    CLS_REGISTER = 3'b111
  } prs_cls_t;

  typedef struct packed {
    logic            valid;
    logic [VA_W-1:0] vaddr;
    prs_cls_t        cls;
  } prs_req_t;

  typedef struct packed {
    logic              valid;
    logic [PA_W-1:0]   paddr;
    logic              dspace;
    logic [MODE_W-1:0] mode;
  } prs_rsp_t;

endpackage : prs_pkg

// ==== test/prs_core_model.sv ====
`timescale 1ns/10ps
module prs_core_model (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Reference port
  input  wire prs_pkg::prs_rsp_t i_rsp,
  output prs_pkg::prs_req_t      o_req
);
  import prs_pkg::*;

  // ****************************************
  // Reference issue
  // ****************************************
  // Valid drops and the address is inverted once released, so a stale request never looks valid
  task automatic issue(input logic [15:0] va, input prs_cls_t cls,
                       output prs_rsp_t rsp);
    @(posedge i_clk);
    o_req <= '{valid: 1'b1, vaddr: va, cls: cls};
    @(posedge i_clk);
    o_req.valid <= 1'b0;
    o_req.vaddr <= ~va;
    #1;
    rsp = i_rsp;
  endtask : issue

  initial o_req = '0;
endmodule : prs_core_model

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import prs_pkg::*;

  logic        clk, rst_n, wr, rd, vec_load, psw_wr, exec_priv, priv_fault;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, new_psw;
  logic [1:0]  stack_bank, cur_mode;
  prs_req_t    req;
  prs_rsp_t    rsp;
  int          fail_count, checked;

  prs_page_select i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_req(req),
    .o_rsp(rsp), .i_vec_load(vec_load), .i_psw_wr(psw_wr),
    .i_new_psw(new_psw), .i_exec_priv(exec_priv),
    .o_priv_fault(priv_fault), .o_stack_bank(stack_bank),
    .o_cur_mode(cur_mode));
  prs_core_model i_core (.i_clk(clk), .i_rst_n(rst_n), .i_rsp(rsp),
    .o_req(req));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check_val(rdata, exp);
  endtask : rd_chk

  // Mode change, then stack bank and current mode compared
  task automatic set_psw(input logic vec, input logic [15:0] processor_status_word);
    @(posedge clk);
    vec_load <= vec;
    psw_wr   <= !vec;
    new_psw  <= processor_status_word;
    @(posedge clk);
    vec_load <= 1'b0;
    psw_wr   <= 1'b0;
    #1;
    check_val(stack_bank, processor_status_word[15:14]);
    check_val(cur_mode, processor_status_word[15:14]);
  endtask : set_psw

  task automatic priv(input logic exp);
    @(posedge clk);
    exec_priv <= 1'b1;
    @(posedge clk);
    exec_priv <= 1'b0;
    #1;
    check_val(priv_fault, exp);
  endtask : priv

  task automatic ref_chk(input logic [15:0] va, input prs_cls_t cls,
                         input logic [21:0] pa, input logic ds);
    prs_rsp_t r;
    i_core.issue(va, cls, r);
    check_val(r.valid, 1'b1);
    check_val(r.paddr, pa);
    check_val(r.dspace, ds);
  endtask : ref_chk

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #500000;
    fail_count++;
    finish_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    prs_rsp_t r;
    prs_cls_t ic[4];
    rst_n      = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = '0;
    wdata      = '0;
    vec_load   = 1'b0;
    psw_wr     = 1'b0;
    new_psw    = '0;
    exec_priv  = 1'b0;
    fail_count = 0;
    checked    = 0;
    ic = '{CLS_INSTR, CLS_IMM, CLS_ABS, CLS_INDEX};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h82, 16'h0000);
    rd_chk(8'h80, 16'h0000);
    ref_chk(16'h2040, CLS_DATA, 22'h002040, 1'b0);
    $display("test reset done");

    wr_reg(8'h01, 16'h0100);
    wr_reg(8'h09, 16'h0200);
    wr_reg(8'h07, 16'h0FFF);
    wr_reg(8'h81, 16'h0001);
    ref_chk(16'h2040, CLS_DATA, 22'h004040, 1'b0);
    wr_reg(8'h80, 16'h0004);
    ref_chk(16'h2040, CLS_DATA, 22'h008040, 1'b1);
    ref_chk(16'h2040, CLS_INDIRECT, 22'h008040, 1'b1);
    foreach (ic[k]) ref_chk(16'h2040, ic[k], 22'h004040, 1'b0);
    i_core.issue(16'h2040, CLS_REGISTER, r);
    check_val(r.valid, 1'b0);
    ref_chk(16'hFFFF, CLS_INSTR, 22'h041FBF, 1'b0);
    rd_chk(8'h83, 16'h107E);
    $display("test mapping done");

    wr_reg(8'h31, 16'h0300);
    // Reference right behind the vector load must see the new mode
    fork
      set_psw(1'b1, 16'hC000);
      begin
        @(posedge clk);
        i_core.issue(16'h2040, CLS_DATA, r);
      end
    join
    check_val(r.paddr, 22'h00C040);
    check_val(r.mode, 2'h3);
    ref_chk(16'h2040, CLS_DATA, 22'h00C040, 1'b0);
    ref_chk(16'h2040, CLS_VECTOR, 22'h008040, 1'b1);
    i_core.issue(16'h2040, CLS_VECTOR, r);
    check_val(r.mode, 2'h0);
    rd_chk(8'h83, 16'h0201);
    rd_chk(8'h82, 16'hC000);
    priv(1'b1);
    set_psw(1'b0, 16'h4000);
    priv(1'b1);
    set_psw(1'b0, 16'h0000);
    priv(1'b0);
    $display("test modes done");

    wr_reg(8'h01, 16'hFFFF);
    rd_chk(8'h01, 16'hFFFF);
    wr_reg(8'h41, 16'h1234);
    rd_chk(8'h41, 16'h1234);
    rd_chk(8'hC0, 16'h0000);
    $display("test registers done");
    finish_test;
  end
endmodule : testbench
